// ===== include/adsh_cfg.svh
// constants for the converter sample/hold controller
`ifndef ADSH_CFG_SVH
`define ADSH_CFG_SVH
`define ADSH_RES_BITS 13
`define ADSH_NUM_BUF 20
`define ADSH_BUF_W 16
`define ADSH_CONV_CYC 15
`define ADSH_PROC_CYC 4
`define ADSH_MIN_DIV 8'h08
`define ADSH_SH0_BUF 5'h12
`define ADSH_SH1_BUF 5'h13
`define ADSH_SRC_TEMP_INT 5'h10
`define ADSH_SRC_TEMP_EXT 5'h11
`define ADSH_SRC_SUPPLY 5'h12
`define ADSH_SRC_REF_INT 5'h13
`define ADSH_SRC_REF_A 5'h14
`define ADSH_SRC_REF_B 5'h15
`define ADSH_GAIN_RST_A 16'h1200
`define ADSH_GAIN_RST_B 16'h0600
`define ADSH_GAIN_RST_C 16'h2400
`define ADSH_GAIN_RST_D 16'h4800
`endif

// ===== include/adsh_pkg.sv
// types for the converter sample/hold controller
`default_nettype none
package adsh_pkg;
  // per-channel settings
  typedef struct packed {
    logic diff;
    logic align_left;
    logic acq_ext;
    logic [1:0] ref_sel;
    logic ext_temp;
    logic [1:0] range;
  } adsh_chcfg_t;
  // hold channel control
  typedef struct packed {
    logic shared_trig;
    logic en1;
    logic en0;
  } adsh_hold_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ACQ = 6'b000010,
    ST_CONV = 6'b000100,
    ST_PROC = 6'b001000,
    ST_STORE = 6'b010000,
    ST_NEXT = 6'b100000
  } adsh_state_t;
endpackage
`default_nettype wire

// ===== design/adsh_ctrl.sv
// converter controller: sequencing, clock divide, averaging, buffers, flags
`include "adsh_cfg.svh"
`default_nettype none
// Behaviour
// - results are thirteen bits wide
// - sixteen single or eight differential inputs
// - internal sources selectable as channel codes
// - internal temperature code used only there
// - continuous repeats; single runs then shuts down
// - four ranges, each with trim gain
// - divided conversion clock, minimum divide eight
// - fifteen conversion clocks plus four core
// - convert twice, store average
// - acquisition extension lengthens sampling
// - per-channel settings held separately
// - twenty sixteen-bit result buffers
// - ready flag after programmed sample count
// - ready flag cleared by software or start
// - two hold channels enabled by bits
// - hold trigger captures, converts, stores reserved slot
// - shared trigger bit joins hold triggers
// - hold flags set on completion, software clear
module adsh_ctrl (
  input wire logic mclk, // 20 MHz core clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic start, // pulse: begin a sequence
  input wire logic stop, // pulse: end continuous sequence
  input wire logic continuous, // 1 continuous, 0 single sequence
  input wire logic [4:0] first_ch, // first channel of the sequence
  input wire logic [4:0] last_ch, // last channel of the sequence
  input wire logic [7:0] clk_div, // conversion clock divide ratio
  input wire logic [7:0] acq_ext_cyc, // extra acquisition cycles
  input wire logic [4:0] ready_count, // samples before ready flag
  input wire logic cfg_we, // pulse: write channel settings
  input wire logic [4:0] cfg_idx, // channel whose settings are written
  input wire adsh_pkg::adsh_chcfg_t cfg_data, // channel settings value
  input wire logic [1:0] gain_sel, // which range trim to write
  input wire logic gain_we, // pulse: write range trim
  input wire logic [15:0] gain_data, // range trim value
  input wire adsh_pkg::adsh_hold_t hold_channel_control, // hold enables and sharing
  input wire logic [1:0] hold_trigger_pin, // hold triggers from pins
  input wire logic ready_clr, // pulse: clear conversion ready flag
  input wire logic [1:0] hold_ready_clr, // pulses: clear hold flags
  input wire logic [4:0] rd_idx, // result buffer to read
  input wire logic [12:0] core_data, // converter core raw result
  output logic [15:0] rd_data, // registered buffer read data
  output logic conversion_clock, // divided conversion clock out
  output logic [4:0] mux_sel, // mux source code
  output logic mux_diff, // mux differential pairing
  output logic [1:0] ref_sel, // reference selection to core
  output logic [15:0] gain_out, // trim of selected range
  output logic sampling, // core sampling phase
  output logic shutdown, // core power down
  output logic conversion_ready_flag, // sequence results ready
  output logic [1:0] hold_ready_flag // hold results ready
);
  // ========================================
  // state and storage
  adsh_pkg::adsh_state_t state;
  adsh_pkg::adsh_chcfg_t chcfg [0:`ADSH_NUM_BUF-1]; // per channel settings
  logic [15:0] buffer [0:`ADSH_NUM_BUF-1]; // result buffers
  logic [15:0] gain [0:3]; // range trims
  logic [7:0] div_cnt; // clock divider count
  logic conv_edge; // one core cycle per conversion clock rise
  logic [7:0] step_cnt; // phase counter
  logic pass; // second conversion of the pair
  logic [12:0] first_res; // first conversion held for averaging
  logic [15:0] result; // averaged, aligned result
  logic [4:0] cur_ch; // channel being converted
  logic [4:0] done_cnt; // samples completed
  logic hold_job; // current conversion serves a hold channel
  logic hold_which; // which hold channel
  logic run_seq; // sequence active
  logic [1:0] trig_s1, trig_s2, trig_s3; // trigger synchroniser and edge
  logic [1:0] hold_pend; // hold captures awaiting conversion
  logic [1:0] trig_rise;
  logic [7:0] eff_div;

  // clamp divide to the fastest allowed ratio
  function automatic logic [7:0] clamp_div(input logic [7:0] d);
    clamp_div = (d < `ADSH_MIN_DIV) ? `ADSH_MIN_DIV : d;
  endfunction

  // average two raw results and align them
  function automatic logic [15:0] avg_align(input logic [12:0] a, input logic [12:0] b,
                                            input logic left);
    logic [13:0] s;
    s = {1'b0, a} + {1'b0, b};
    avg_align = left ? {s[13:1], 3'b000} : {3'b000, s[13:1]};
  endfunction

  assign eff_div = clamp_div(clk_div);

  // ========================================
  // conversion clock divider, free running
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      div_cnt <= 8'h00;
      conversion_clock <= 1'b0;
      conv_edge <= 1'b0;
    end else if (div_cnt >= eff_div - 8'h01) begin
      div_cnt <= 8'h00;
      conversion_clock <= 1'b1;
      conv_edge <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      conv_edge <= 1'b0;
      // half duty for even divides (odd ones run one cycle longer low) so the core sees a clean clock
      if (div_cnt == {1'b0, eff_div[7:1]} - 8'h01) conversion_clock <= 1'b0;
    end
  end

  // ========================================
  // trigger synchroniser; stage one only feeds stage two
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      trig_s1 <= 2'b00;
      trig_s2 <= 2'b00;
      trig_s3 <= 2'b00;
    end else begin
      trig_s1 <= hold_trigger_pin;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  // shared mode lets trigger zero fire both holds
  always_comb begin
    trig_rise = trig_s2 & ~trig_s3;
    if (hold_channel_control.shared_trig) trig_rise = {2{trig_rise[0]}};
  end

  // ========================================
  // settings storage
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < `ADSH_NUM_BUF; i++) chcfg[i] <= '0;
    end else if (cfg_we && cfg_idx < 5'(`ADSH_NUM_BUF)) begin
      chcfg[cfg_idx] <= cfg_data;
    end
  end

  // trims reset to the nominal full scales
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gain[0] <= `ADSH_GAIN_RST_A;
      gain[1] <= `ADSH_GAIN_RST_B;
      gain[2] <= `ADSH_GAIN_RST_C;
      gain[3] <= `ADSH_GAIN_RST_D;
    end else if (gain_we) begin
      gain[gain_sel] <= gain_data;
    end
  end

  // ========================================
  // main sequencer
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= adsh_pkg::ST_IDLE;
      step_cnt <= 8'h00;
      pass <= 1'b0;
      first_res <= 13'h0000;
      cur_ch <= 5'h00;
      hold_job <= 1'b0;
      hold_which <= 1'b0;
      run_seq <= 1'b0;
      hold_pend <= 2'b00;
      done_cnt <= 5'h00;
      result <= 16'h0000;
    end else begin
      // captures arriving now are kept, except one for the hold already being converted, which its store clears
      hold_pend <= hold_pend | (trig_rise & {hold_channel_control.en1,
                                              hold_channel_control.en0});
      if (stop) run_seq <= 1'b0;
      case (state)
        adsh_pkg::ST_IDLE: begin
          // hold captures take priority over the sequence
          if (hold_pend != 2'b00) begin
            hold_job <= 1'b1;
            hold_which <= !hold_pend[0];
            cur_ch <= hold_pend[0] ? `ADSH_SH0_BUF : `ADSH_SH1_BUF;
            state <= adsh_pkg::ST_ACQ;
            step_cnt <= 8'h00;
            pass <= 1'b0;
          end else if (start || run_seq) begin
            if (start) begin
              run_seq <= 1'b1;
              cur_ch <= first_ch;
              done_cnt <= 5'h00;
            end
            hold_job <= 1'b0;
            state <= adsh_pkg::ST_ACQ;
            step_cnt <= 8'h00;
            pass <= 1'b0;
          end
        end
        adsh_pkg::ST_ACQ: begin
          // extension only when the channel asks for it
          if (!chcfg[cur_ch].acq_ext || step_cnt >= acq_ext_cyc) begin
            state <= adsh_pkg::ST_CONV;
            step_cnt <= 8'h00;
          end else begin
            step_cnt <= step_cnt + 8'h01;
          end
        end
        adsh_pkg::ST_CONV: begin
          if (conv_edge) begin
            if (step_cnt == 8'(`ADSH_CONV_CYC - 1)) begin
              step_cnt <= 8'h00;
              state <= adsh_pkg::ST_PROC;
            end else begin
              step_cnt <= step_cnt + 8'h01;
            end
          end
        end
        adsh_pkg::ST_PROC: begin
          if (step_cnt == 8'(`ADSH_PROC_CYC - 1)) begin
            step_cnt <= 8'h00;
            if (!pass) begin
              first_res <= core_data;
              pass <= 1'b1;
              state <= adsh_pkg::ST_CONV;
            end else begin
              result <= avg_align(first_res, core_data, chcfg[cur_ch].align_left);
              state <= adsh_pkg::ST_STORE;
            end
          end else begin
            step_cnt <= step_cnt + 8'h01;
          end
        end
        adsh_pkg::ST_STORE: begin
          state <= adsh_pkg::ST_NEXT;
          // a capture landing in the store cycle stays pending: set beats clear
          if (hold_job) hold_pend[hold_which] <= trig_rise[hold_which] &&
              (hold_which ? hold_channel_control.en1 : hold_channel_control.en0);
          else done_cnt <= done_cnt + 5'h01;
        end
        adsh_pkg::ST_NEXT: begin
          state <= adsh_pkg::ST_IDLE;
          if (!hold_job) begin
            if (cur_ch == last_ch) begin
              cur_ch <= first_ch;
              if (!continuous) run_seq <= 1'b0;
            end else begin
              cur_ch <= cur_ch + 5'h01;
            end
          end
        end
        default: state <= adsh_pkg::ST_IDLE;
      endcase
    end
  end

  // ========================================
  // result buffers written in store, flags follow one cycle later
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < `ADSH_NUM_BUF; i++) buffer[i] <= 16'h0000;
    end else if (state == adsh_pkg::ST_STORE && cur_ch < 5'(`ADSH_NUM_BUF)) begin
      buffer[cur_ch] <= result;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) rd_data <= 16'h0000;
    else if (rd_idx < 5'(`ADSH_NUM_BUF)) rd_data <= buffer[rd_idx];
    else rd_data <= 16'h0000;
  end

  // ========================================
  // ready flags: set beats clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      conversion_ready_flag <= 1'b0;
    end else if (state == adsh_pkg::ST_NEXT && !hold_job && done_cnt >= ready_count) begin
      conversion_ready_flag <= 1'b1;
    end else if (ready_clr || (state == adsh_pkg::ST_IDLE && start)) begin
      conversion_ready_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hold_ready_flag <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (state == adsh_pkg::ST_NEXT && hold_job && hold_which == 1'(i))
          hold_ready_flag[i] <= 1'b1;
        else if (hold_ready_clr[i])
          hold_ready_flag[i] <= 1'b0;
      end
    end
  end

  // ========================================
  // core-facing outputs, all registered
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mux_sel <= 5'h00;
      mux_diff <= 1'b0;
      ref_sel <= 2'b00;
      gain_out <= `ADSH_GAIN_RST_A;
      sampling <= 1'b0;
      shutdown <= 1'b1;
    end else begin
      // codes 0..15 inputs, 16.. internal sources; temp code only for die temp
      mux_sel <= cur_ch;
      mux_diff <= chcfg[cur_ch].diff;
      ref_sel <= chcfg[cur_ch].ref_sel;
      gain_out <= gain[chcfg[cur_ch].range];
      sampling <= (state == adsh_pkg::ST_ACQ);
      shutdown <= (state == adsh_pkg::ST_IDLE) && !run_seq && (hold_pend == 2'b00);
    end
  end

  // ========================================
  // checks
  property p_div_min;
    @(posedge mclk) disable iff (!resetn) conv_edge |=> !conv_edge [*7];
  endproperty
  a_div_min: assert property (p_div_min) else $error("conversion clock faster than eight");

  property p_conv_len;
    @(posedge mclk) disable iff (!resetn)
      (state == adsh_pkg::ST_PROC && $past(state) == adsh_pkg::ST_CONV)
        |-> $past(step_cnt) == 8'(`ADSH_CONV_CYC - 1) && $past(conv_edge);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too short");

  sequence s_store;
    state == adsh_pkg::ST_STORE;
  endsequence
  property p_flag_after_store;
    @(posedge mclk) disable iff (!resetn)
      $rose(conversion_ready_flag) |-> $past(state, 2) == adsh_pkg::ST_STORE;
  endproperty
  a_flag_after_store: assert property (p_flag_after_store) else $error("flag before store");

  property p_store_write;
    @(posedge mclk) disable iff (!resetn)
      s_store ##1 1'b1 |-> buffer[cur_ch] == result;
  endproperty
  a_store_write: assert property (p_store_write) else $error("buffer not written");

  property p_hold_sticky;
    @(posedge mclk) disable iff (!resetn)
      hold_ready_flag[0] && !hold_ready_clr[0] |=> hold_ready_flag[0];
  endproperty
  a_hold_sticky: assert property (p_hold_sticky) else $error("hold flag lost");

  property p_ready_start_clr;
    @(posedge mclk) disable iff (!resetn)
      (state == adsh_pkg::ST_IDLE && start && hold_pend == 2'b00) |=> !conversion_ready_flag;
  endproperty
  a_ready_start_clr: assert property (p_ready_start_clr) else $error("flag kept at start");

  property p_shutdown;
    @(posedge mclk) disable iff (!resetn)
      state != adsh_pkg::ST_IDLE |=> !shutdown;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown while busy");

  property p_avg;
    @(posedge mclk) disable iff (!resetn)
      s_store |-> result == avg_align(first_res, $past(core_data), chcfg[cur_ch].align_left);
  endproperty
  a_avg: assert property (p_avg) else $error("average wrong");
endmodule // adsh_ctrl
`default_nettype wire

// ===== verification/adsh_core_model.sv
// converter core stand-in: raw codes that differ between the two passes of a channel
`default_nettype none
module adsh_core_model (
  input wire logic mclk, // core clock
  input wire logic sampling, // acquisition phase from the controller
  input wire logic conversion_clock, // divided conversion clock
  output logic [12:0] core_data // raw result toward the controller
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // job and edge counters
  int jobs = 0; // acquisitions seen, numbers the raw codes
  int edges = 0; // conversion clock rises since acquisition ended
  logic [12:0] first_code; // code of the first pass
  initial core_data = 13'h1555;
  always @(posedge sampling) begin
    jobs++;
  end
  // restart the pass count at every acquisition
  always @(posedge conversion_clock or posedge sampling) begin
    if (sampling)
      edges = 0;
    else
      edges++;
  end
  assign first_code = 13'h0456 + 13'(jobs) * 13'h0123;
  // ==========================================
  // raw result: noise while acquiring, so a result taken too early shows
  always @(posedge mclk) begin
    if (sampling)
      core_data <= ~core_data;
    else if (edges < 23)
      core_data <= first_code;
    else
      core_data <= first_code ^ 13'h1abc;
  end
endmodule // adsh_core_model
`default_nettype wire

// ===== verification/adsh_ctrl_tb.sv
// self-checking bench for the converter sample/hold controller
`default_nettype none
module adsh_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // design hookup
  logic mclk = 0, resetn = 0, start = 0, stop = 0, continuous = 0, cfg_we = 0, gain_we = 0;
  logic [4:0] first_ch = 0, last_ch = 0, ready_count = 0, cfg_idx = 0, rd_idx = 0;
  logic [7:0] clk_div = 8'h08, acq_ext_cyc = 0;
  adsh_pkg::adsh_chcfg_t cfg_data = 0; // settings being written
  logic [1:0] gain_sel = 0, hold_trigger_pin = 0, hold_ready_clr = 0, ref_sel, hold_ready_flag;
  logic [15:0] gain_data = 0, rd_data, gain_out;
  adsh_pkg::adsh_hold_t hold_channel_control = 0; // hold enables
  logic ready_clr = 0, conversion_clock, mux_diff, sampling, shutdown, conversion_ready_flag;
  logic [12:0] core_data; // from the core model
  logic [4:0] mux_sel;
  adsh_ctrl uut (.mclk, .resetn, .start, .stop, .continuous, .first_ch, .last_ch, .clk_div,
    .acq_ext_cyc, .ready_count, .cfg_we, .cfg_idx, .cfg_data, .gain_sel, .gain_we, .gain_data,
    .hold_channel_control, .hold_trigger_pin, .ready_clr, .hold_ready_clr, .rd_idx, .core_data,
    .rd_data, .conversion_clock, .mux_sel, .mux_diff, .ref_sel, .gain_out, .sampling, .shutdown,
    .conversion_ready_flag, .hold_ready_flag);
  adsh_core_model core (.mclk, .sampling, .conversion_clock, .core_data);
  always #25 mclk = ~mclk;
  // ==========================================
  // reference model state
  adsh_pkg::adsh_chcfg_t cfg [0:19]; // settings per channel
  logic [15:0] gains [0:3] = '{16'h1200, 16'h0600, 16'h2400, 16'h4800};
  logic [15:0] exp_buf [0:31] = '{default: 16'h0000}; // 20 and up read as zero
  int jobs [$]; // buffer index of each expected acquisition, in order
  int seed = 32'h2247_738f;
  int num_errors = 0, check_count = 0, cyc = 0, k = 0, since = 0, cur = 0, acq = 0;
  int per = 0, nr = 0;
  logic prev_s = 0, prev_c = 0, prev_f = 0;
  // average of the two passes, placed as the channel asks
  function automatic logic [15:0] expect_word(input int n, input logic left);
    logic [12:0] a;
    logic [13:0] sum;
    a = 13'h0456 + 13'(n) * 13'h0123;
    sum = {1'b0, a} + {1'b0, a ^ 13'h1abc};
    return left ? {sum[13:1], 3'b000} : {3'b000, sum[13:1]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want) begin
      num_errors++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task automatic summarize;
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick;
    @(posedge mclk);
    #5;
  endtask
  // ==========================================
  // monitor: acquisitions, clock period, flag timing, timeout
  // cycle ceiling: a hang counts as a mismatch and goes to the verdict
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  always @(posedge mclk) begin
    if (sampling && !prev_s) begin
      k++;
      since++;
      acq = 0;
      cur = (jobs.size() > 0) ? jobs.pop_front() : 31;
    end
    if (sampling) begin
      acq++;
      nr = 0;
    end
    if (!sampling && prev_s && cur < 20) begin
      if (cur < 18) begin
        chk(16'(acq), cfg[cur].acq_ext ? 16'(acq_ext_cyc) + 16'h0001 : 16'h0001);
        chk(gain_out, gains[cfg[cur].range]);
        chk(16'(ref_sel), 16'(cfg[cur].ref_sel));
        chk(16'(mux_diff), 16'(cfg[cur].diff));
        if (!cfg[cur].diff) chk(16'(mux_sel), 16'(cur));
      end
      exp_buf[cur] = expect_word(k, cfg[cur].align_left);
    end
    if (conversion_clock && !prev_c) begin
      nr++;
      if (!sampling && nr > 2 && nr < 6)
        chk(16'(per), clk_div < 8 ? 16'h0008 : 16'(clk_div));
      per = 0;
    end
    per++;
    if (conversion_ready_flag && !prev_f) chk(16'(since), 16'(ready_count));
    prev_s = sampling;
    prev_c = conversion_clock;
    prev_f = conversion_ready_flag;
  end
  // ==========================================
  // stimulus tasks
  task automatic rd(input int i);
    rd_idx = 5'(i);
    tick;
    chk(rd_data, exp_buf[i]);
  endtask
  task automatic run_seq(input int f, input int l, input logic cont, input int n);
    first_ch = 5'(f);
    last_ch = 5'(l);
    continuous = cont;
    ready_count = 5'(n);
    for (int p = 0; p < (cont ? 3 : 1); p++) begin
      for (int c = f; c <= l; c++) jobs.push_back(c);
    end
    since = 0;
    start = 1;
    tick;
    start = 0;
    tick;
    tick;
    chk(16'(conversion_ready_flag), 16'h0000);
  endtask
  // the outside party raises the trigger pin
  task automatic trig(input logic [1:0] p);
    hold_trigger_pin = p;
    repeat (4) tick;
    hold_trigger_pin = 2'b00;
    tick;
  endtask
  task automatic hold_clear(input logic [1:0] m);
    hold_ready_clr = m;
    tick;
    hold_ready_clr = 2'b00;
    tick;
    chk(16'(hold_ready_flag), 16'h0000);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (2) tick;
    resetn = 1;
    tick;
    chk(16'(shutdown), 16'h0001);
    chk(16'({hold_ready_flag, conversion_ready_flag}), 16'h0000);
    rd(3);
    clk_div = 8'($unsigned($random(seed)) % 5 + 6);
    acq_ext_cyc = 8'($random(seed) & 15);
    for (int i = 0; i < 20; i++) begin
      cfg_idx = 5'(i);
      cfg_data = (i >= 18) ? 8'h00 : 8'($random(seed));
      cfg[i] = cfg_data;
      cfg_we = 1;
      tick;
    end
    cfg_we = 0;
    gain_sel = 2'($random(seed));
    gain_data = 16'($random(seed));
    gains[gain_sel] = gain_data;
    gain_we = 1;
    tick;
    gain_we = 0;
    // single sequence over the last inputs and the die temperature code
    run_seq(13, 16, 0, 4);
    repeat (20) tick;
    start = 1; // ignored while busy
    tick;
    start = 0;
    while (conversion_ready_flag !== 1'b1) tick;
    repeat (3) tick;
    chk(16'(shutdown), 16'h0001);
    for (int c = 13; c <= 16; c++) rd(c);
    rd(21);
    // continuous run started while the flag still stands
    run_seq(4, 5, 1, 3);
    while (conversion_ready_flag !== 1'b1) tick;
    chk(16'(shutdown), 16'h0000);
    stop = 1;
    tick;
    stop = 0;
    repeat (1200) tick; // longer than one channel at the slowest divide used
    jobs.delete();
    rd(4);
    rd(5);
    ready_clr = 1;
    tick;
    ready_clr = 0;
    tick;
    chk(16'(conversion_ready_flag), 16'h0000);
    // hold channel 0 alone: the disabled trigger does nothing
    hold_channel_control = 3'b001;
    jobs.push_back(18);
    trig(2'b10);
    trig(2'b01);
    while (hold_ready_flag[0] !== 1'b1) tick;
    repeat (50) tick;
    chk(16'(hold_ready_flag), 16'h0001);
    rd(18);
    rd(19);
    hold_clear(2'b01);
    // both holds on one shared trigger
    hold_channel_control = 3'b111;
    jobs.push_back(18);
    jobs.push_back(19);
    trig(2'b01);
    while (hold_ready_flag !== 2'b11) tick;
    rd(18);
    rd(19);
    hold_clear(2'b11);
    // separate triggers: only the second hold answers its pin
    hold_channel_control = 3'b011;
    jobs.push_back(19);
    trig(2'b10);
    while (hold_ready_flag[1] !== 1'b1) tick;
    repeat (50) tick;
    chk(16'(hold_ready_flag), 16'h0002);
    rd(19);
    summarize();
  end
endmodule // adsh_ctrl_tb
`default_nettype wire
